// ==== hdl/alarm_flags_pkg.sv ====
// package for the alarm condition flag bank
// assumes one 40 MHz clock domain and byte-wide register access
package alarm_flags_pkg;

   // ----------------------------------------
   // register map and field positions
   // ----------------------------------------
   localparam logic [7:0] ALARM_CONDITION_FLAGS_ADDR = 8'hC1;  // status register offset (low byte)
   localparam logic [7:0] PER_LANE_FAULT_ADDR = 8'hC3;         // per-lane fault register offset
   localparam logic [7:0] ALARM_MASK_ADDR = 8'hC2;             // mask register offset
   localparam int LANE_BUFFER_FAULT_BIT = 5;                   // lane buffer overflow/underflow
   localparam int SERIALIZER_PLL_UNLOCK_BIT = 4;               // serializer pll unlock
   localparam int LINK_STATE_FAULT_BIT = 3;                    // link state fault
   localparam logic [7:0] FLAGS_RESET = 8'h38;                 // all kept flags set after reset
   localparam logic [7:0] MASK_RESET = 8'h3F;                  // all alarms masked after reset
   localparam logic [7:0] FLAGS_USED = 8'h38;                  // bits implemented in this block
   localparam int LANES_DEFAULT = 8;                           // number of serial lanes

   // ----------------------------------------
   // carriers
   // ----------------------------------------
   // register port request
   typedef struct packed
   {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_t;

   // link encoding mode
   typedef enum logic
   {
      ENC_8B10B,
      ENC_64B66B
   } link_enc_t;

endpackage

// ==== hdl/flag_cell.sv ====
// one sticky flag with write-one-to-clear
// assumes set and clear arrive synchronous to clk
`timescale 1ns/1ps
`default_nettype none
module flag_cell
#(
   parameter logic RESET_VALUE = 1'b1
)
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic en,
   input wire logic set,
   input wire logic clr,
   output logic flag_q
);

   logic flag_d; // next flag value

   // set beats clear, zero written leaves it alone
   always_comb
   begin
      flag_d = flag_q;
      if (clr)
      begin
         flag_d = 1'b0;
      end
      if (set)
      begin
         flag_d = 1'b1;
      end
   end

   // flag register, frozen while en low
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         flag_q <= RESET_VALUE;
      end
      else if (en)
      begin
         flag_q <= flag_d;
      end
   end

endmodule
`default_nettype wire

// ==== hdl/serdes_alarm_status_flags.sv ====
// alarm condition flag bank for the serial link
// What this block does
// RQ1: lane overflow or underflow sets bit five
// RQ2: flags stay until written one to clear
// RQ3: per-lane register records which lane faulted
// RQ4: pll unlock sets bit four, reset one
// RQ5: 8b10b link enabled not in data sets
// RQ6: 64b66b startup or realignment sets link flag
// RQ7: all flags one after power or soft reset
// RQ8: aggregate alarm high for unmasked set flags
// RQ9: flags undefined while link disabled; clear after (not done here, left to software)
// RQ10: zero write keeps; persisting condition sets again
// assumes register accesses are one-cycle strobes on clk
`timescale 1ns/1ps
`default_nettype none
module serdes_alarm_status_flags
#(
   parameter int LANES = alarm_flags_pkg::LANES_DEFAULT
)
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic clk_en,
   input wire logic soft_reset,
   input wire alarm_flags_pkg::reg_req_t req,
   output logic [7:0] rdata_q,
   output logic rvalid_q,
   input wire logic [LANES-1:0] lane_active,
   input wire logic [LANES-1:0] lane_overflow,
   input wire logic [LANES-1:0] lane_underflow,
   input wire logic pll_locked,
   input wire logic serial_link_enable,
   input wire alarm_flags_pkg::link_enc_t enc_mode,
   input wire logic user_data_state,
   input wire logic realign_event,
   output logic alarm_q
);

   // ----------------------------------------
   // reset release
   // ----------------------------------------
   logic [1:0] rst_sync_q; // two-stage release of nrst
   logic rst_n;            // synchronised reset

   // release reset through two flops
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         rst_sync_q <= 2'h0;
      end
      else
      begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   // only the second stage feeds the rest of the block
   assign rst_n = rst_sync_q[1];

   // ----------------------------------------
   // helper functions
   // ----------------------------------------
   // true when a strobe addresses the given register
   function automatic logic reg_hit
   (
      input logic strobe,
      input logic [7:0] addr,
      input logic [7:0] target
   );
      return strobe && (addr == target);
   endfunction

   // ----------------------------------------
   // register decode
   // ----------------------------------------
   logic wr_flags;  // write to status register
   logic wr_lane;   // write to per-lane register
   logic wr_mask;   // write to mask register
   logic [7:0] flags;          // current flag values
   logic [LANES-1:0] lane_q;   // per-lane sticky faults
   logic [LANES-1:0] lane_d;
   logic [7:0] mask_q;         // alarm mask
   logic [7:0] mask_d;
   logic link_en_q;            // link enable seen last cycle
   logic link_en_d;
   logic [LANES-1:0] lane_fault; // lanes faulting now
   logic [2:0] set_vec;        // set requests for bits 5..3
   logic [7:0] rdata_d;
   logic rvalid_d;
   logic alarm_d;

   // write strobes, one per register
   assign wr_flags = reg_hit(req.wr, req.addr, alarm_flags_pkg::ALARM_CONDITION_FLAGS_ADDR);
   assign wr_lane = reg_hit(req.wr, req.addr, alarm_flags_pkg::PER_LANE_FAULT_ADDR);
   assign wr_mask = reg_hit(req.wr, req.addr, alarm_flags_pkg::ALARM_MASK_ADDR);

   // ----------------------------------------
   // set conditions
   // ----------------------------------------
   // decode the three alarm conditions each cycle
   always_comb
   begin
      // RQ1: active lane fault
      lane_fault = lane_active & (lane_overflow | lane_underflow);
      set_vec[2] = |lane_fault;
      // RQ4: pll not locked
      set_vec[1] = !pll_locked;
      // RQ5: link fault per mode
      if (enc_mode == alarm_flags_pkg::ENC_8B10B)
      begin
         set_vec[0] = serial_link_enable && !user_data_state;
      end
      else
      begin
         // RQ6: startup edge or realignment
         set_vec[0] = serial_link_enable && (!link_en_q || realign_event);
      end
   end

   // ----------------------------------------
   // sticky flags
   // ----------------------------------------
   // RQ2: write one clears each flag
   // RQ7: reset value one
   // RQ10: set wins over clear
   // bit five: lane buffer fault
   flag_cell
   #(
      .RESET_VALUE(alarm_flags_pkg::FLAGS_RESET[alarm_flags_pkg::LANE_BUFFER_FAULT_BIT])
   )
   u_lane_buffer_fault_flag
   (
      .clk(clk),
      .rst_n(rst_n && !soft_reset),
      .en(clk_en),
      .set(set_vec[2]),
      .clr(wr_flags && req.wdata[alarm_flags_pkg::LANE_BUFFER_FAULT_BIT]),
      .flag_q(flags[alarm_flags_pkg::LANE_BUFFER_FAULT_BIT])
   );
   // bit four: serializer pll unlock
   flag_cell
   #(
      .RESET_VALUE(alarm_flags_pkg::FLAGS_RESET[alarm_flags_pkg::SERIALIZER_PLL_UNLOCK_BIT])
   )
   u_serializer_pll_unlock_flag
   (
      .clk(clk),
      .rst_n(rst_n && !soft_reset),
      .en(clk_en),
      .set(set_vec[1]),
      .clr(wr_flags && req.wdata[alarm_flags_pkg::SERIALIZER_PLL_UNLOCK_BIT]),
      .flag_q(flags[alarm_flags_pkg::SERIALIZER_PLL_UNLOCK_BIT])
   );
   // bit three: link state fault
   flag_cell
   #(
      .RESET_VALUE(alarm_flags_pkg::FLAGS_RESET[alarm_flags_pkg::LINK_STATE_FAULT_BIT])
   )
   u_link_state_fault_flag
   (
      .clk(clk),
      .rst_n(rst_n && !soft_reset),
      .en(clk_en),
      .set(set_vec[0]),
      .clr(wr_flags && req.wdata[alarm_flags_pkg::LINK_STATE_FAULT_BIT]),
      .flag_q(flags[alarm_flags_pkg::LINK_STATE_FAULT_BIT])
   );
   // unimplemented bits read zero
   assign flags[7:6] = 2'h0;
   assign flags[2:0] = 3'h0;

   // ----------------------------------------
   // per-lane record, mask, read, alarm
   // ----------------------------------------
   // next values for lane record, mask, read port and alarm
   always_comb
   begin
      // RQ3: record faulting lanes, w1c
      lane_d = lane_q;
      if (wr_lane)
      begin
         lane_d = lane_d & ~req.wdata[LANES-1:0];
      end
      lane_d = lane_d | lane_fault;
      mask_d = wr_mask ? req.wdata : mask_q;
      // RQ7: soft reset reloads record and mask
      if (soft_reset)
      begin
         lane_d = '1;
         mask_d = alarm_flags_pkg::MASK_RESET;
      end
      // RQ6: remember enable for startup edge
      link_en_d = serial_link_enable;
      rvalid_d = req.rd;
      rdata_d = rdata_q;
      // read mux, answered on the next edge
      if (req.rd)
      begin
         unique case (req.addr)
            alarm_flags_pkg::ALARM_CONDITION_FLAGS_ADDR: rdata_d = flags;
            alarm_flags_pkg::PER_LANE_FAULT_ADDR: rdata_d = 8'(lane_q);
            alarm_flags_pkg::ALARM_MASK_ADDR: rdata_d = mask_q;
            default: rdata_d = 8'h00;
         endcase
      end
      // RQ8: unmasked flag raises alarm, one cycle behind
      alarm_d = |(flags & ~mask_q & alarm_flags_pkg::FLAGS_USED);
   end

   // register state only; RQ9 left to software after enable
   always_ff @(posedge clk or negedge rst_n)
   begin
      // hardware reset defaults
      if (!rst_n)
      begin
         lane_q <= '1;
         mask_q <= alarm_flags_pkg::MASK_RESET;
         link_en_q <= 1'b0;
         rdata_q <= 8'h00;
         rvalid_q <= 1'b0;
         alarm_q <= 1'b0;
      end
      // advance only while clock enable high
      else if (clk_en)
      begin
         lane_q <= lane_d;
         mask_q <= mask_d;
         link_en_q <= link_en_d;
         rdata_q <= rdata_d;
         rvalid_q <= rvalid_d;
         alarm_q <= alarm_d;
      end
   end

endmodule
`default_nettype wire

// ==== sim/serdes_alarm_status_flags_asserts.sv ====
// checker for the alarm flag bank, bound to its top
// assumes one clock and reads answered one cycle later
`timescale 1ns/1ps
`default_nettype none
module serdes_alarm_status_flags_asserts #(parameter int LANES = alarm_flags_pkg::LANES_DEFAULT)
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic clk_en,
   input wire logic soft_reset,
   input wire alarm_flags_pkg::reg_req_t req,
   input wire logic [7:0] rdata_q,
   input wire logic rvalid_q,
   input wire logic pll_locked
);
   // ------------------------------
   // status reads and clears
   // ------------------------------
   wire logic st = clk_en && req.addr == alarm_flags_pkg::ALARM_CONDITION_FLAGS_ADDR;  // status access taken
   default clocking dc @(posedge clk);
   endclocking
   default disable iff (!nrst);
   // plain status read
   sequence s_rd;
      st && req.rd && !req.wr && !soft_reset;
   endsequence
   // write one to the pll bit
   sequence s_clr;
      st && req.wr && req.wdata[4] && !soft_reset;
   endsequence
   a_read_answered:
      assert property (clk_en && req.rd |=> rvalid_q) else $error("read not answered");
   a_idle_quiet:
      assert property (clk_en && !req.rd |=> !rvalid_q) else $error("stray read valid");
   a_unmapped_zero:
      assert property (clk_en && req.rd && req.addr < 8'hC1 |=> rdata_q == 8'h00) else $error("unmapped not zero");
   a_reserved_zero:
      assert property (s_rd |=> (rdata_q & 8'hC7) == 8'h00) else $error("reserved bits set");
   a_pll_unlock_set:
      assert property ((clk_en && !pll_locked) ##1 !req.wr ##1 s_rd |=> rdata_q[4]) else $error("unlock missed");
   a_flag_sticky:
      assert property (s_rd ##1 (!req.wr && !req.rd) ##1 s_rd |=> (rdata_q & $past(rdata_q)) == $past(rdata_q))
         else $error("flag lost");
   a_clear_works:
      assert property ((s_clr and pll_locked) ##1 (pll_locked && !soft_reset) ##1 s_rd |=> !rdata_q[4])
         else $error("flag not cleared");
   a_recovery_set:
      assert property ((s_clr and (!pll_locked)) ##1 !pll_locked ##1 s_rd |=> rdata_q[4]) else $error("clear beat set");
endmodule
bind serdes_alarm_status_flags serdes_alarm_status_flags_asserts #(.LANES(LANES)) u_chk
   (.clk, .nrst, .clk_en, .soft_reset, .req, .rdata_q, .rvalid_q, .pll_locked);
`default_nettype wire

// ==== sim/serdes_alarm_status_flags_tb.sv ====
// self-checking bench for the alarm flag bank
// assumes the checker binds itself to the design
`timescale 1ns/1ps
`default_nettype none
module serdes_alarm_status_flags_tb;
   // ------------------------------
   // signals, tasks and scenarios
   // ------------------------------
   localparam logic [7:0] ST = alarm_flags_pkg::ALARM_CONDITION_FLAGS_ADDR;  // status
   localparam logic [7:0] MK = alarm_flags_pkg::ALARM_MASK_ADDR;  // mask
   localparam logic [7:0] LN = alarm_flags_pkg::PER_LANE_FAULT_ADDR;  // lane record
   logic clk = 1'b0, nrst = 1'b0, clk_en = 1'b1, soft_reset = 1'b0, pll_locked = 1'b1, rvalid_q, alarm_q;
   logic serial_link_enable = 1'b1, user_data_state = 1'b1, realign_event = 1'b0;
   logic [7:0] lane_active = 8'hFF, lane_overflow = 8'h00, lane_underflow = 8'h00, rdata_q;
   alarm_flags_pkg::reg_req_t req = '0;
   alarm_flags_pkg::link_enc_t enc_mode = alarm_flags_pkg::ENC_8B10B;
   int n_errors = 0, checks_done = 0;
   serdes_alarm_status_flags #(.LANES(8)) dut (.clk, .nrst, .clk_en, .soft_reset, .req, .rdata_q, .rvalid_q,
      .lane_active, .lane_overflow, .lane_underflow, .pll_locked, .serial_link_enable, .enc_mode,
      .user_data_state, .realign_event, .alarm_q);
   initial forever #12.5 clk = ~clk;
   // wait edges, then step just past the last
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // count a comparison, report a miss
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         n_errors++;
         $display("MISMATCH at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   // one-cycle access strobe, write or read
   task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
      cyc(1);
      req = '{w, !w, a, d};
      cyc(1);
      req = '0;
   endtask
   // read, then check answer and masked data
   task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic [7:0] m = 8'hFF);
      acc(1'b0, a, 8'h00);
      chk({7'h00, rvalid_q}, 8'h01);
      chk(rdata_q & m, exp);
   endtask
   // counts and verdict
   task automatic wrap_up;
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   initial
   begin
      cyc(4);
      nrst = 1'b1;
      cyc(3);
      rd(ST, 8'h38);
      rd(MK, 8'h3F);
      rd(LN, 8'hFF);
      acc(1'b1, ST, 8'h00);
      rd(ST, 8'h38);
      acc(1'b1, ST, 8'hFF);
      acc(1'b1, LN, 8'hFF);
      acc(1'b1, MK, 8'h00);
      rd(ST, 8'h00);
      chk({7'h00, alarm_q}, 8'h00);
      // unlock, link out of data, lane 2 overflow, inactive lane 7 underflow
      {pll_locked, user_data_state, lane_active, lane_overflow, lane_underflow} = {2'b00, 24'h7F0480};
      cyc(1);
      {pll_locked, user_data_state, lane_overflow, lane_underflow} = {2'b11, 16'h0000};
      rd(ST, 8'h38);
      rd(LN, 8'h04);
      chk({7'h00, alarm_q}, 8'h01);
      acc(1'b1, MK, 8'h10);
      pll_locked = 1'b0;
      acc(1'b1, ST, 8'hFF);
      rd(ST, 8'h10);
      chk({7'h00, alarm_q}, 8'h00);
      pll_locked = 1'b1;
      acc(1'b1, ST, 8'hFF);
      rd(ST, 8'h00);
      enc_mode = alarm_flags_pkg::ENC_64B66B;
      user_data_state = 1'b0;
      acc(1'b1, ST, 8'hFF);
      rd(ST, 8'h00);
      realign_event = 1'b1;
      cyc(1);
      realign_event = 1'b0;
      rd(ST, 8'h08);
      serial_link_enable = 1'b0;
      acc(1'b1, ST, 8'hFF);
      serial_link_enable = 1'b1;
      cyc(1);
      clk_en = 1'b0;
      acc(1'b1, ST, 8'hFF);
      clk_en = 1'b1;
      rd(ST, 8'h08, 8'h08);
      rd(8'h00, 8'h00);
      soft_reset = 1'b1;
      cyc(1);
      soft_reset = 1'b0;
      rd(ST, 8'h38);
      rd(ST, 8'h38);
      rd(LN, 8'hFF);
      wrap_up();
   end
endmodule
`default_nettype wire
